/* verilog/gid_decoder.sv */
/*
 * Graphics instruction decoder with AXI4-Lite control/status registers.
 * Assumes the fetch unit and execution datapath share aclk with it.
 */
// How it works
// - 1110 000 register form is XY add, updates N C Z V.
// - 1110 010 register form is XY compare, three cycles, N C Z V.
// - 1110 011 register form is point-window compare, one cycle, V only.
// - 1110 100 register form converts XY to linear, three cycles, no flags.
// - 0F C0 is linear fill, 0F E0 is XY fill; only XY touches V.
// - DF with low byte Z001 1010 is line draw; Z is option; V.
// - 1110 110 and 1110 111 copy X or Y half, one cycle, no flags.
// - 0F x0 third nibble picks block transfer kind; XY targets touch V.
// - 1111 100 is pixel store indirect; 1111 000 XY store touches V.
// - 1111 101 load, four cycles; 1111 001 XY load, six; no flags.
// - 1111 110 indirect copy; 1111 010 XY copy alone touches V.
// - 1110 001 register form is XY subtract, one cycle, N C Z V.
// - Source is bits 8..5, destination bits 3..0, bit 4 picks file.
// - Variable operations get a duration from pixel, array and options.
// - Index fifteen in either file means the shared stack pointer.
`timescale 1ns/1ps

module gid_decoder (
	// Clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// Fetch side
	input  wire logic                 fetch_valid,
	input  wire logic [15:0]          fetch_word,
	// Decoded controls
	output logic                      dec_valid,
	output gid_pkg::gid_op_e          dec_op,
	output gid_pkg::gid_blt_e         dec_blt,
	output logic                      dec_in_group,
	output logic                      dec_undefined,
	output logic [3:0]                dec_src,
	output logic [3:0]                dec_dst,
	output logic                      dec_file_b,
	output logic                      dec_src_sp,
	output logic                      dec_dst_sp,
	output logic                      dec_draw_opt,
	output logic [1:0]                dec_words,
	output logic [7:0]                dec_min_cycles,
	output logic                      dec_variable,
	output logic [31:0]               dec_duration,
	output logic [3:0]                dec_flags,
	// Interrupt
	output logic                      irq,
	// AXI4-Lite slave
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready
);
	import gid_pkg::*;

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [1:0]  status_r;
	logic [1:0]  mask_r;
	logic        enable_r;
	logic [15:0] last_word_r;
	logic [4:0]  psize_r;
	logic [2:0]  opts_r;
	logic [31:0] array_r;
	logic [7:0]  aw_addr_r;
	logic        aw_have_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	logic        w_have_r;
	logic        wr_go;
	logic        wr_hit;

	// Byte-lane merge; used by the mask and array registers.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	function automatic logic is_mapped(input logic [7:0] a);
		return a == GID_OFF_STATUS || a == GID_OFF_MASK ||
			a == GID_OFF_CTRL || a == GID_OFF_LAST ||
			a == GID_OFF_PIXCFG || a == GID_OFF_ARRAY ||
			a == GID_OFF_CYCLES;
	endfunction : is_mapped

	// ------------------------------------------------------------
	// Combinational decode
	// ------------------------------------------------------------
	gid_op_e     op_c;
	gid_blt_e    blt_c;
	logic        grp_c;
	logic [7:0]  cyc_c;
	logic        var_c;
	logic [3:0]  fl_c;
	logic [31:0] dur_c;
	logic [31:0] pix_cnt;
	logic [31:0] bits_cnt;

	always_comb begin
		op_c  = GID_OP_NONE;
		blt_c = GID_BLT_NONE;
		cyc_c = GID_CYC_ONE;
		var_c = 1'b0;
		fl_c  = GID_FL_NONE;
		grp_c = 1'b0;
		if (fetch_word[15:12] == 4'hE) begin
			grp_c = 1'b1;
			unique case (fetch_word[11:9])
				3'h0: begin
					op_c = GID_XY_ADD_OP;
					fl_c = GID_FL_NCZV;
				end
				3'h1: begin
					op_c = GID_XY_SUBTRACT_OP;
					fl_c = GID_FL_NCZV;
				end
				3'h2: begin
					op_c  = GID_XY_COMPARE_OP;
					cyc_c = GID_CYC_XY_COMPARE_OP;
					fl_c  = GID_FL_NCZV;
				end
				3'h3: begin
					op_c = GID_POINT_WINDOW_COMPARE_OP;
					fl_c = GID_FL_V;
				end
				3'h4: begin
					op_c  = GID_XY_TO_LINEAR_OP;
					cyc_c = GID_CYC_XY_TO_LINEAR_OP;
				end
				3'h5: op_c = GID_OP_UNDEF;
				3'h6: op_c = GID_COPY_X_HALF_OP;
				3'h7: op_c = GID_COPY_Y_HALF_OP;
			endcase
		end else if (fetch_word[15:12] == 4'hF) begin
			grp_c = 1'b1;
			var_c = 1'b1;
			unique case (fetch_word[11:9])
				3'h0: begin
					op_c = GID_PIX_STORE_XY_OP;
					fl_c = GID_FL_V;
				end
				3'h1: begin
					op_c  = GID_PIX_LOAD_XY_OP;
					cyc_c = GID_CYC_PIXLDX;
					var_c = 1'b0;
				end
				3'h2: begin
					op_c = GID_PIX_COPY_XY_OP;
					fl_c = GID_FL_V;
				end
				3'h3: begin
					op_c = GID_DRAW_ADVANCE_OP;
					fl_c = GID_FL_V;
				end
				3'h4: op_c = GID_PIX_STORE_OP;
				3'h5: begin
					op_c  = GID_PIX_LOAD_OP;
					cyc_c = GID_CYC_PIXLD;
					var_c = 1'b0;
				end
				3'h6: op_c = GID_PIX_COPY_OP;
				3'h7: begin
					op_c  = GID_OP_UNDEF;
					var_c = 1'b0;
				end
			endcase
		end else if (fetch_word[15:8] == 8'hDF) begin
			grp_c = 1'b1;
			op_c  = GID_OP_UNDEF;
			if (fetch_word[6:0] == 7'h1A) begin
				op_c  = GID_LINE_DRAW_OP;
				var_c = 1'b1;
				fl_c  = GID_FL_V;
			end
		end else if (fetch_word[15:8] == 8'h0F) begin
			grp_c = 1'b1;
			op_c  = GID_OP_UNDEF;
			if (fetch_word[3:0] == 4'h0) begin
				var_c = 1'b1;
				op_c  = GID_BLOCK_TRANSFER_OP;
				unique case (fetch_word[7:4])
					4'h8: blt_c = GID_BLT_BIN_LIN;
					4'hA: blt_c = GID_BLT_BIN_XY;
					4'h0: blt_c = GID_BLT_LIN_LIN;
					4'h2: blt_c = GID_BLT_LIN_XY;
					4'h4: blt_c = GID_BLT_XY_LIN;
					4'h6: blt_c = GID_BLT_XY_XY;
					4'hC: op_c = GID_FILL_LINEAR_OP;
					4'hE: op_c = GID_FILL_XY_OP;
					default: begin
						op_c  = GID_OP_UNDEF;
						var_c = 1'b0;
					end
				endcase
				// XY destinations are the odd-numbered second bit.
				if (fetch_word[5] && op_c != GID_FILL_LINEAR_OP &&
					op_c != GID_OP_UNDEF) begin
					fl_c = GID_FL_V;
				end
			end
		end
	end

	// Duration scales with pixels moved, their width, and any options
	// selected; a coarse estimate, not a cycle-exact model.
	always_comb begin
		pix_cnt  = 32'(array_r[15:0] * array_r[31:16]);
		bits_cnt = 32'(pix_cnt * psize_r);
		dur_c    = 32'(cyc_c);
		if (var_c) begin
			dur_c = 32'((bits_cnt >> 4) + 32'(cyc_c));
			if (opts_r != 3'h0) begin
				dur_c = 32'(dur_c + pix_cnt);
			end
		end
	end

	// ------------------------------------------------------------
	// Decoded output registers
	// ------------------------------------------------------------
	logic take;
	assign take = fetch_valid & enable_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dec_valid <= 1'b0;
		end else begin
			dec_valid <= take;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dec_op         <= GID_OP_NONE;
			dec_blt        <= GID_BLT_NONE;
			dec_in_group   <= 1'b0;
			dec_undefined  <= 1'b0;
			dec_src        <= 4'h0;
			dec_dst        <= 4'h0;
			dec_file_b     <= 1'b0;
			dec_src_sp     <= 1'b0;
			dec_dst_sp     <= 1'b0;
			dec_draw_opt   <= 1'b0;
			dec_words      <= 2'h0;
			dec_min_cycles <= 8'h00;
			dec_variable   <= 1'b0;
			dec_duration   <= 32'h0;
			dec_flags      <= GID_FL_NONE;
			last_word_r    <= 16'h0;
		end else if (take) begin
			dec_op         <= op_c;
			dec_blt        <= blt_c;
			dec_in_group   <= grp_c;
			dec_undefined  <= op_c == GID_OP_UNDEF;
			dec_src        <= fetch_word[8:5];
			dec_dst        <= fetch_word[3:0];
			dec_file_b     <= fetch_word[4];
			dec_src_sp     <= fetch_word[8:5] == GID_SP_INDEX;
			dec_dst_sp     <= fetch_word[3:0] == GID_SP_INDEX;
			dec_draw_opt   <= fetch_word[7];
			dec_words      <= grp_c ? GID_WORDS_ONE : 2'h0;
			dec_min_cycles <= cyc_c;
			dec_variable   <= var_c;
			dec_duration   <= dur_c;
			dec_flags      <= fl_c;
			last_word_r    <= fetch_word;
		end
	end

	// ------------------------------------------------------------
	// Interrupt status, mask and output
	// ------------------------------------------------------------
	logic [1:0] ev;
	assign ev[GID_EV_UNDEF] = take & (op_c == GID_OP_UNDEF);
	assign ev[GID_EV_DONE]  = take & grp_c & (op_c != GID_OP_UNDEF);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_r <= GID_STATUS_RST;
		end else begin
			// A new event wins over a simultaneous write-one-to-clear.
			status_r <= (status_r & ~((wr_go && aw_addr_r ==
				GID_OFF_STATUS && w_strb_r[0]) ? w_data_r[1:0] : 2'h0))
				| ev;
		end
	end

	assign irq = |(status_r & mask_r);

	// ------------------------------------------------------------
	// AXI4-Lite write path
	// ------------------------------------------------------------
	assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_have_r & ~s_axi_bvalid;
	assign wr_go         = aw_have_r & w_have_r & ~s_axi_bvalid;
	assign wr_hit        = is_mapped(aw_addr_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_have_r  <= 1'b0;
			w_data_r  <= 32'h0;
			w_strb_r  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_have_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (wr_go) begin
				w_have_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= GID_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? GID_RESP_OKAY : GID_RESP_DECERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_r   <= GID_MASK_RST;
			enable_r <= GID_CTRL_RST;
			psize_r  <= GID_PSIZE_RST;
			opts_r   <= GID_OPTS_RST;
			array_r  <= GID_ARRAY_RST;
		end else if (wr_go) begin
			unique case (aw_addr_r)
				GID_OFF_MASK: mask_r <= 2'(merge(32'(mask_r),
					w_data_r, w_strb_r));
				GID_OFF_CTRL: enable_r <= w_strb_r[0] ? w_data_r[0]
					: enable_r;
				GID_OFF_PIXCFG: begin
					if (w_strb_r[0]) begin
						psize_r <= w_data_r[4:0];
					end
					if (w_strb_r[1]) begin
						opts_r <= w_data_r[GID_OPTS_LSB +: 3];
					end
				end
				GID_OFF_ARRAY: array_r <= merge(array_r, w_data_r,
					w_strb_r);
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read path
	// ------------------------------------------------------------
	logic [31:0] rd_c;
	assign s_axi_arready = ~s_axi_rvalid;

	always_comb begin
		unique case (s_axi_araddr)
			GID_OFF_STATUS: rd_c = 32'(status_r);
			GID_OFF_MASK:   rd_c = 32'(mask_r);
			GID_OFF_CTRL:   rd_c = 32'(enable_r);
			GID_OFF_LAST:   rd_c = 32'(last_word_r);
			GID_OFF_PIXCFG: rd_c = {21'h0, opts_r, 3'h0, psize_r};
			GID_OFF_ARRAY:  rd_c = array_r;
			GID_OFF_CYCLES: rd_c = dec_duration;
			default:        rd_c = 32'h0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= GID_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_c;
			s_axi_rresp  <= is_mapped(s_axi_araddr) ? GID_RESP_OKAY
				: GID_RESP_DECERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : gid_decoder

/* verilog/gid_pkg.sv */
/*
 * Constants and types shared by the graphics instruction decoder.
 * Assumes a 32-bit AXI4-Lite register bus and a 16-bit fetch word.
 */
package gid_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] GID_OFF_STATUS = 8'h00;
	localparam logic [7:0] GID_OFF_MASK   = 8'h04;
	localparam logic [7:0] GID_OFF_CTRL   = 8'h08;
	localparam logic [7:0] GID_OFF_LAST   = 8'h0C;
	localparam logic [7:0] GID_OFF_PIXCFG = 8'h10;
	localparam logic [7:0] GID_OFF_ARRAY  = 8'h14;
	localparam logic [7:0] GID_OFF_CYCLES = 8'h18;

	// ------------------------------------------------------------
	// Reset values and field positions
	// ------------------------------------------------------------
	localparam logic [1:0]  GID_STATUS_RST = 2'h0;
	localparam logic [1:0]  GID_MASK_RST   = 2'h0;
	localparam logic        GID_CTRL_RST   = 1'h1;
	localparam logic [4:0]  GID_PSIZE_RST  = 5'h10;
	localparam logic [2:0]  GID_OPTS_RST   = 3'h0;
	localparam logic [31:0] GID_ARRAY_RST  = 32'h0001_0001;
	localparam int          GID_EV_UNDEF   = 0;
	localparam int          GID_EV_DONE    = 1;
	localparam int          GID_OPTS_LSB   = 8;

	// Flag update mask bit positions: {sign, carry, zero, overflow}.
	localparam logic [3:0] GID_FL_NONE = 4'h0;
	localparam logic [3:0] GID_FL_V    = 4'h1;
	localparam logic [3:0] GID_FL_NCZV = 4'hF;

	// ------------------------------------------------------------
	// Minimum cycle counts, stack pointer index and word count
	// ------------------------------------------------------------
	localparam logic [7:0] GID_CYC_ONE    = 8'h01;
	localparam logic [7:0] GID_CYC_XY_COMPARE_OP  = 8'h03;
	localparam logic [7:0] GID_CYC_XY_TO_LINEAR_OP  = 8'h03;
	localparam logic [7:0] GID_CYC_PIXLD  = 8'h04;
	localparam logic [7:0] GID_CYC_PIXLDX = 8'h06;
	localparam logic [3:0] GID_SP_INDEX   = 4'hF;
	localparam logic [1:0] GID_WORDS_ONE  = 2'h1;

	// AXI responses.
	localparam logic [1:0] GID_RESP_OKAY   = 2'h0;
	localparam logic [1:0] GID_RESP_DECERR = 2'h3;

	typedef enum logic [4:0] {
		GID_OP_NONE,
		GID_XY_ADD_OP,
		GID_XY_SUBTRACT_OP,
		GID_XY_COMPARE_OP,
		GID_POINT_WINDOW_COMPARE_OP,
		GID_XY_TO_LINEAR_OP,
		GID_COPY_X_HALF_OP,
		GID_COPY_Y_HALF_OP,
		GID_DRAW_ADVANCE_OP,
		GID_FILL_LINEAR_OP,
		GID_FILL_XY_OP,
		GID_LINE_DRAW_OP,
		GID_BLOCK_TRANSFER_OP,
		GID_PIX_STORE_OP,
		GID_PIX_STORE_XY_OP,
		GID_PIX_LOAD_OP,
		GID_PIX_LOAD_XY_OP,
		GID_PIX_COPY_OP,
		GID_PIX_COPY_XY_OP,
		GID_OP_UNDEF
	} gid_op_e;

	typedef enum logic [2:0] {
		GID_BLT_NONE,
		GID_BLT_BIN_LIN,
		GID_BLT_BIN_XY,
		GID_BLT_LIN_LIN,
		GID_BLT_LIN_XY,
		GID_BLT_XY_LIN,
		GID_BLT_XY_XY
	} gid_blt_e;

endpackage : gid_pkg

/* testbench/gid_fetch_model.sv */
/*
 * Model of the fetch unit that offers first words to the decoder.
 * Assumes the bench calls send from one thread, one word at a time.
 */
`timescale 1ns/1ps

module gid_fetch_model (
	// Clock
	input  wire logic        aclk,
	// Fetch side
	output logic             fetch_valid,
	output logic [15:0]      fetch_word
);

	initial begin
		fetch_valid = 1'b0;
		fetch_word  = 16'h0000;
	end

	// Between words the bus shows the inverse of the last word, so a
	// decoder that samples a stale word can never match by luck.
	task send(input logic [15:0] w);
		@(posedge aclk);
		fetch_valid <= 1'b1;
		fetch_word  <= w;
		@(posedge aclk);
		fetch_valid <= 1'b0;
		fetch_word  <= ~w;
	endtask : send

endmodule : gid_fetch_model

/* testbench/gid_decoder_chk.sv */
/*
 * Concurrent checks on the decoder's fetch and decode ports.
 * Assumes it is bound into gid_decoder and sees only its ports.
 */
`timescale 1ns/1ps

module gid_decoder_chk (
	// Clock and reset
	input  wire logic                aclk,
	input  wire logic                aresetn,
	// Fetch side
	input  wire logic                fetch_valid,
	input  wire logic [15:0]         fetch_word,
	// Decoded controls
	input  wire logic                dec_valid,
	input  wire gid_pkg::gid_op_e    dec_op,
	input  wire logic                dec_undefined,
	input  wire logic [3:0]          dec_src,
	input  wire logic [3:0]          dec_dst,
	input  wire logic                dec_file_b,
	input  wire logic                dec_src_sp,
	input  wire logic                dec_dst_sp,
	input  wire logic                dec_draw_opt,
	input  wire logic [7:0]          dec_min_cycles,
	input  wire logic [3:0]          dec_flags
);
	import gid_pkg::*;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_add_decode: assert property (
		dec_valid && $past(fetch_word[15:9]) == 7'h70 |->
		dec_op == GID_XY_ADD_OP && dec_flags == 4'hF)
		else $error("add word decoded wrongly");
	chk_sub_decode: assert property (
		dec_valid && $past(fetch_word[15:9]) == 7'h71 |->
		dec_op == GID_XY_SUBTRACT_OP && dec_min_cycles == 8'h01)
		else $error("subtract word decoded wrongly");
	chk_compare_cycles: assert property (
		dec_valid && $past(fetch_word[15:9]) == 7'h72 |->
		dec_min_cycles == 8'h03 && dec_flags == 4'hF)
		else $error("compare cycles or flags wrong");
	chk_window_flags: assert property (
		dec_valid && $past(fetch_word[15:9]) == 7'h73 |->
		dec_flags == 4'h1 && dec_min_cycles == 8'h01)
		else $error("window compare flags wrong");
	chk_convert_flags: assert property (
		dec_valid && $past(fetch_word[15:9]) == 7'h74 |->
		dec_flags == 4'h0 && dec_min_cycles == 8'h03)
		else $error("convert flags or cycles wrong");
	chk_draw_flags: assert property (
		dec_valid && $past(fetch_word[15:9]) == 7'h7B |->
		dec_op == GID_DRAW_ADVANCE_OP && dec_flags == 4'h1)
		else $error("draw advance decoded wrongly");
	chk_load_cycles: assert property (
		dec_valid && $past(fetch_word[15:12]) == 4'hF &&
		$past(fetch_word[10:9]) == 2'h1 |-> dec_flags == 4'h0 &&
		dec_min_cycles == ($past(fetch_word[11]) ? 8'h04 : 8'h06))
		else $error("pixel load cycles wrong");
	chk_field_split: assert property (
		dec_valid |-> dec_src == $past(fetch_word[8:5]) &&
		dec_dst == $past(fetch_word[3:0]) &&
		dec_file_b == $past(fetch_word[4]))
		else $error("register fields split wrongly");
	chk_stack_index: assert property (
		dec_valid |-> dec_src_sp == (dec_src == 4'hF) &&
		dec_dst_sp == (dec_dst == 4'hF))
		else $error("stack pointer index wrong");
	chk_line_option: assert property (
		dec_valid && dec_op == GID_LINE_DRAW_OP |->
		dec_draw_opt == $past(fetch_word[7]) &&
		$past(fetch_word[6:0]) == 7'h1A)
		else $error("line draw option wrong");
	chk_undef_mark: assert property (
		dec_valid |-> dec_undefined == (dec_op == GID_OP_UNDEF))
		else $error("undefined mark disagrees");

endmodule : gid_decoder_chk

/* testbench/tb_graphics_instruction_decoder.sv */
/*
 * Self-checking bench for the graphics instruction decoder.
 * Assumes gid_pkg, gid_decoder, the fetch model and the checker.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("wrong value %s exp %0h got %0h", n, e, g); \
	end \
end

module tb_graphics_instruction_decoder;
	import gid_pkg::*;

	// Entries are indexed by opcode bits 12..9 of the register forms.
	localparam logic [4:0] RG_OP [16] = '{5'h1, 5'h2, 5'h3, 5'h4, 5'h5,
		5'h13, 5'h6, 5'h7, 5'hE, 5'h10, 5'h12, 5'h8, 5'hD, 5'hF, 5'h11, 5'h13};
	localparam logic [3:0] RG_FL [16] = '{4'hF, 4'hF, 4'hF, 4'h1, 4'h0,
		4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0};
	localparam logic [7:0] RG_MIN [16] = '{8'h1, 8'h1, 8'h3, 8'h1, 8'h3,
		8'h1, 8'h1, 8'h1, 8'h1, 8'h6, 8'h1, 8'h1, 8'h1, 8'h4, 8'h1, 8'h1};
	localparam logic [15:0] RG_VAR = 16'h5D00;
	localparam logic [2:0] BLT_K [8] = '{3'h3, 3'h4, 3'h5, 3'h6, 3'h1,
		3'h2, 3'h0, 3'h0};

	logic              aclk, aresetn, fetch_valid, dec_valid, irq;
	logic [15:0]       fetch_word, w;
	gid_op_e           dec_op;
	gid_blt_e          dec_blt;
	logic              dec_in_group, dec_undefined, dec_file_b;
	logic              dec_src_sp, dec_dst_sp, dec_draw_opt, dec_variable;
	logic [3:0]        dec_src, dec_dst, dec_flags, wstrb;
	logic [1:0]        dec_words, bresp, rresp;
	logic [7:0]        dec_min_cycles, awaddr, araddr;
	logic [31:0]       dec_duration, wdata, rdata, seed;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	int                error_cnt, comparisons, cycles;

	gid_fetch_model fm (.aclk(aclk), .fetch_valid(fetch_valid),
		.fetch_word(fetch_word));

	gid_decoder dut (.aclk(aclk), .aresetn(aresetn),
		.fetch_valid(fetch_valid), .fetch_word(fetch_word),
		.dec_valid(dec_valid), .dec_op(dec_op), .dec_blt(dec_blt),
		.dec_in_group(dec_in_group), .dec_undefined(dec_undefined),
		.dec_src(dec_src), .dec_dst(dec_dst), .dec_file_b(dec_file_b),
		.dec_src_sp(dec_src_sp), .dec_dst_sp(dec_dst_sp),
		.dec_draw_opt(dec_draw_opt), .dec_words(dec_words),
		.dec_min_cycles(dec_min_cycles), .dec_variable(dec_variable),
		.dec_duration(dec_duration), .dec_flags(dec_flags), .irq(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));

	// ------------------------------------------------------------
	// Expectations and bus tasks
	// ------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs

	// Result is {op, blt, flags, min cycles, variable, group, undef}.
	function automatic logic [22:0] exp_dec(input logic [15:0] x);
		logic [4:0] o;
		logic [2:0] b;
		logic [3:0] f;
		logic [7:0] m;
		logic       v;
		logic       g;
		int         k;
		k = {x[12], x[11:9]};
		o = 5'h0;
		b = 3'h0;
		f = 4'h0;
		m = 8'h1;
		v = 1'b0;
		g = x[15:13] == 3'h7 || x[15:8] == 8'h0F || x[15:8] == 8'hDF;
		if (x[15:13] == 3'h7) begin
			o = RG_OP[k];
			f = RG_FL[k];
			m = RG_MIN[k];
			v = RG_VAR[k];
		end else if (x[15:8] == 8'h0F && x[4:0] == 5'h0) begin
			k = x[7:5];
			o = (k < 6) ? 5'hC : 5'(9 + k - 6);
			b = BLT_K[k];
			f = {3'h0, x[5]};
			v = 1'b1;
		end else if (x[15:8] == 8'hDF && x[6:0] == 7'h1A) begin
			o = 5'hB;
			f = 4'h1;
			v = 1'b1;
		end else if (g) begin
			o = 5'h13;
		end
		return {o, b, f, m, v, g, o == 5'h13};
	endfunction : exp_dec

	function automatic logic [31:0] exp_dur(input int x, y, ps, op);
		return 32'(((x * y * ps) >> 4) + 1 + (op != 0 ? x * y : 0));
	endfunction : exp_dur

	task chk_word(input logic [15:0] x);
		logic [22:0] e;
		e = exp_dec(x);
		fm.send(x);
		#1;
		`CHK("valid", 1'b1, dec_valid)
		`CHK("op", e[22:18], dec_op)
		`CHK("blt", e[17:15], dec_blt)
		`CHK("group", e[1], dec_in_group)
		`CHK("undef", e[0], dec_undefined)
		`CHK("src", x[8:5], dec_src)
		`CHK("dst", x[3:0], dec_dst)
		`CHK("file", x[4], dec_file_b)
		`CHK("sp", x[3:0] == 4'hF, dec_dst_sp)
		`CHK("words", e[1] ? 2'h1 : 2'h0, dec_words)
		if (e[1] && !e[0]) begin
			`CHK("flags", e[14:11], dec_flags)
			`CHK("min", e[10:3], dec_min_cycles)
			`CHK("var", e[2], dec_variable)
		end
		if (e[22:18] == 5'hB)
			`CHK("opt", x[7], dec_draw_opt)
	endtask : chk_word

	task axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		`CHK("bresp", er, bresp)
	endtask : axi_wr

	task axi_rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		`CHK("rdata", ed, rdata)
		`CHK("rresp", er, rresp)
	endtask : axi_rd

	task stop_test;
		if (error_cnt == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test

	// ------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			error_cnt++;
			stop_test();
		end
	end

	initial begin
		{aresetn, awaddr, wdata, wstrb, awvalid, wvalid, bready} = '0;
		{araddr, arvalid, rready, error_cnt, comparisons, cycles} = '0;
		seed = 32'h0000_042A;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(GID_OFF_STATUS, 32'h0, GID_RESP_OKAY);
		axi_rd(GID_OFF_MASK, 32'h0, GID_RESP_OKAY);
		axi_rd(GID_OFF_CTRL, 32'h1, GID_RESP_OKAY);
		axi_rd(GID_OFF_PIXCFG, 32'h10, GID_RESP_OKAY);
		axi_rd(GID_OFF_ARRAY, 32'h0001_0001, GID_RESP_OKAY);
		axi_rd(8'h1C, 32'h0, GID_RESP_DECERR);
		axi_wr(8'h20, 32'hFFFF_FFFF, 4'hF, GID_RESP_DECERR);
		axi_wr(GID_OFF_MASK, 32'h3, 4'h2, GID_RESP_OKAY);
		axi_rd(GID_OFF_MASK, 32'h0, GID_RESP_OKAY);
		for (int k = 0; k < 16; k++) chk_word({3'h7, 4'(k), 5'h1F, 4'(k)});
		for (int k = 0; k < 16; k++) chk_word({8'h0F, 4'(k), 4'h0});
		chk_word(16'h0F01);
		chk_word(16'hDF1A);
		chk_word(16'hDF9A);
		chk_word(16'hDF1B);
		chk_word(16'h4C21);
		repeat (300) begin
			seed = xs(seed);
			w = seed[15:0];
			if (seed[17:16] == 2'h0) w[15:13] = 3'h7;
			if (seed[17:16] == 2'h1)
				w = {8'h0F, seed[7:4], seed[18] ? 4'h0 : seed[3:0]};
			if (seed[17:16] == 2'h2)
				w = {8'hDF, seed[7], seed[18] ? 7'h1A : seed[6:0]};
			chk_word(w);
		end
		axi_wr(GID_OFF_ARRAY, 32'h0002_0003, 4'hF, GID_RESP_OKAY);
		axi_wr(GID_OFF_PIXCFG, 32'h0000_0008, 4'hF, GID_RESP_OKAY);
		chk_word(16'h0FC0);
		`CHK("dur", exp_dur(3, 2, 8, 0), dec_duration)
		axi_wr(GID_OFF_PIXCFG, 32'h0000_0108, 4'hF, GID_RESP_OKAY);
		chk_word(16'h0FE0);
		`CHK("dur", exp_dur(3, 2, 8, 1), dec_duration)
		axi_rd(GID_OFF_CYCLES, exp_dur(3, 2, 8, 1), GID_RESP_OKAY);
		chk_word(16'hE440);
		`CHK("dur", 32'h3, dec_duration)
		axi_wr(GID_OFF_STATUS, 32'h3, 4'hF, GID_RESP_OKAY);
		chk_word(16'hEA00);
		axi_rd(GID_OFF_STATUS, 32'h1, GID_RESP_OKAY);
		`CHK("irq", 1'b0, irq)
		axi_wr(GID_OFF_MASK, 32'h1, 4'hF, GID_RESP_OKAY);
		#1;
		`CHK("irq", 1'b1, irq)
		axi_wr(GID_OFF_STATUS, 32'h1, 4'hF, GID_RESP_OKAY);
		#1;
		`CHK("irq", 1'b0, irq)
		axi_wr(GID_OFF_CTRL, 32'h0, 4'hF, GID_RESP_OKAY);
		fm.send(16'hE021);
		#1;
		`CHK("drop", 1'b0, dec_valid)
		axi_rd(GID_OFF_STATUS, 32'h0, GID_RESP_OKAY);
		axi_wr(GID_OFF_CTRL, 32'h1, 4'hF, GID_RESP_OKAY);
		axi_wr(GID_OFF_MASK, 32'h2, 4'hF, GID_RESP_OKAY);
		chk_word(16'hE021);
		`CHK("irq", 1'b1, irq)
		// A reset in mid-run must clear irq and dec_op and put back the pixel config and array registers.
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		#1;
		`CHK("irq", 1'b0, irq)
		`CHK("rst op", GID_OP_NONE, dec_op)
		axi_rd(GID_OFF_PIXCFG, 32'h10, GID_RESP_OKAY);
		axi_rd(GID_OFF_ARRAY, 32'h0001_0001, GID_RESP_OKAY);
		chk_word(16'hE021);
		stop_test();
	end

endmodule : tb_graphics_instruction_decoder

bind gid_decoder gid_decoder_chk u_chk (.aclk(aclk), .aresetn(aresetn),
	.fetch_valid(fetch_valid), .fetch_word(fetch_word),
	.dec_valid(dec_valid), .dec_op(dec_op),
	.dec_undefined(dec_undefined), .dec_src(dec_src),
	.dec_dst(dec_dst), .dec_file_b(dec_file_b),
	.dec_src_sp(dec_src_sp), .dec_dst_sp(dec_dst_sp),
	.dec_draw_opt(dec_draw_opt), .dec_min_cycles(dec_min_cycles),
	.dec_flags(dec_flags));
